/* rtl/sab_pkg.sv */
// Purpose: Shared constants and types for the converter bus sequencer
// Assumes: One bus clock times both transfers and conversion
// Notes:   Word layouts are bit positions inside the high byte of a 16-bit register word
`default_nettype none

package sab_pkg;

    // ****************************************
    // Conversion timing, in clocks
    // ****************************************
    localparam int ACQ_CLOCKS  = 32;
    localparam int CONV_CLOCKS = 256;
    localparam int SAR_STEPS   = 8;
    localparam int BIT_CLOCKS  = (CONV_CLOCKS - ACQ_CLOCKS) / SAR_STEPS;

    // ****************************************
    // Word fields, reset values and conversion start values
    // ****************************************
    localparam int          START_BIT_POS   = 0;
    localparam int          STATUS_BIT_POS  = 7;
    localparam logic [3:0]  CHANNEL_RESET   = 4'h0;
    localparam logic [8:0]  PTR_FIRST       = 9'h100;
    localparam logic [7:0]  TRIAL_FIRST     = 8'h80;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        SAB_IDLE = 3'b001,
        SAB_ACQ  = 3'b010,
        SAB_CONV = 3'b100
    } sab_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_wr;
        logic       register_select_line;
        logic [7:0] data;
    } sab_req_t;

endpackage

`default_nettype wire

/* rtl/sab_sar.sv */
// Purpose: Acquisition timer and eight-step successive approximation
// Assumes: comp_above is synchronous, high when input is at or above trial level
// Notes:   A start during a conversion aborts it and restarts acquisition
`default_nettype none

module sab_sar (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // Control
    input  wire logic            start,
    input  wire logic            comp_above,
    // Status and data
    output var  sab_pkg::sab_state_t state,
    output logic [7:0]           trial,
    output logic [7:0]           result,
    output logic                 done
);

    logic [4:0] cnt;
    logic [8:0] ptr;
    logic [8:0] age;
    logic [8:0] next_ptr;
    logic [7:0] next_trial;
    logic       step_end;

    assign step_end   = (cnt == 5'(sab_pkg::BIT_CLOCKS - 1));
    assign next_ptr   = ptr >> 1;
    // Drop the tested bit if the input was below it, then post the next one
    assign next_trial = (trial & ~(ptr[8:1] & {8{~comp_above}})) | next_ptr[8:1];

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= sab_pkg::SAB_IDLE;
            cnt   <= 5'h0;
            ptr   <= 9'h000;
            trial <= 8'h00;
        end else if (start) begin
            state <= sab_pkg::SAB_ACQ;
            cnt   <= 5'h0;
            ptr   <= 9'h000;
            trial <= 8'h00;
        end else begin
            case (state)
                sab_pkg::SAB_ACQ: begin
                    cnt <= cnt + 5'h1;
                    if (cnt == 5'(sab_pkg::ACQ_CLOCKS - 1)) begin
                        state <= sab_pkg::SAB_CONV;
                        cnt   <= 5'h0;
                        ptr   <= sab_pkg::PTR_FIRST;
                        trial <= sab_pkg::TRIAL_FIRST;
                    end
                end
                sab_pkg::SAB_CONV: begin
                    cnt <= cnt + 5'h1;
                    if (step_end) begin
                        cnt   <= 5'h0;
                        ptr   <= next_ptr;
                        trial <= next_trial;
                        if (next_ptr[0]) begin
                            state <= sab_pkg::SAB_IDLE;
                        end
                    end
                end
                default: begin
                    state <= sab_pkg::SAB_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Result transfer
    // ****************************************
    // Data register is deliberately not reset, so a result survives reset
    always_ff @(posedge ref_clk) begin
        if (!rst && !start && state == sab_pkg::SAB_CONV && step_end && next_ptr[0]) begin
            result <= next_trial;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= !start && state == sab_pkg::SAB_CONV && step_end && next_ptr[0];
        end
    end

    // Age since start, read only by the checks below
    always_ff @(posedge ref_clk) begin
        if (rst || start) begin
            age <= 9'h000;
        end else if (state != sab_pkg::SAB_IDLE) begin
            age <= age + 9'h001;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    acq_to_conv_a: assert property (
        (state == sab_pkg::SAB_ACQ && cnt == 5'(sab_pkg::ACQ_CLOCKS - 1) && !start)
        |=> (state == sab_pkg::SAB_CONV && trial == sab_pkg::TRIAL_FIRST
             && age == 9'(sab_pkg::ACQ_CLOCKS)))
        else $error("acquisition did not last 32 clocks");
    acq_no_trial_a: assert property (
        state == sab_pkg::SAB_ACQ |-> trial == 8'h00)
        else $error("trial level posted during acquisition");
    ptr_onehot_a: assert property (
        state == sab_pkg::SAB_CONV |-> $onehot(ptr) && !ptr[0])
        else $error("bit pointer not one-hot");
    keep_bit_a: assert property (
        (state == sab_pkg::SAB_CONV && step_end && comp_above && !start)
        |=> (trial & $past(ptr[8:1])) != 8'h00)
        else $error("bit dropped although input above");
    clear_bit_a: assert property (
        (state == sab_pkg::SAB_CONV && step_end && !comp_above && !start)
        |=> (trial & $past(ptr[8:1])) == 8'h00)
        else $error("bit kept although input below");
    conv_length_a: assert property (
        done |-> age == 9'(sab_pkg::CONV_CLOCKS) && state == sab_pkg::SAB_IDLE)
        else $error("conversion not 256 clocks");
    result_copy_a: assert property (
        done |-> result == trial ##1 result == $past(result))
        else $error("result not transferred");

endmodule

`default_nettype wire

/* rtl/sab_top.sv */
// Purpose: Bus decode, byte sequencing and registers of an 8-bit SAR converter
// Assumes: Bus inputs and discrete pins are synchronous to ref_clk
// Notes:   Each clock with cs_n low is one byte transfer; read data follows
//          one clock later on data_out with data_oe high
`default_nettype none

module sab_top (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Processor bus
    input  wire sab_pkg::sab_req_t bus_req,
    output logic [7:0]             data_out,
    output logic                   data_oe,
    // Analog front end
    input  wire logic              comp_above,
    input  wire logic [5:0]        discrete_pin_bits,
    output logic [3:0]             mux_select,
    output logic [7:0]             dac_level,
    output logic                   acquiring,
    output logic                   converting
);

    // ****************************************
    // Internal state
    // ****************************************
    logic                channel_address_bits [3:0];
    logic [3:0]          channel;
    logic                byte_ptr;
    logic                ctl_msb_seen;
    logic                start_conversion_bit;
    logic                status;
    logic                access;
    logic                wr_ctl;
    logic                commit;
    logic                start;
    logic [7:0]          rd_byte;
    logic [15:0]         results_word;
    logic [15:0]         discrete_input_word;
    sab_pkg::sab_state_t state;
    logic [7:0]          trial;
    logic [7:0]          result_bits;
    logic                done;
    logic                start_q;
    logic [8:0]          busy_clocks;

    // Picks the byte of a word that the byte pointer addresses
    function automatic logic [7:0] word_byte(input logic [15:0] word, input logic lsb);
        return lsb ? word[7:0] : word[15:8];
    endfunction

    // ****************************************
    // Bus decode
    // ****************************************
    assign access = !bus_req.cs_n;
    // Write with select 0 is a no-op and decodes to nothing
    assign wr_ctl = access && !bus_req.rd_wr && bus_req.register_select_line;
    // Only the second byte of a full control write takes effect
    assign commit = wr_ctl && byte_ptr && ctl_msb_seen;
    assign start  = commit && start_conversion_bit;

    // Byte pointer: MSB first, flips each byte, back to MSB when deselected
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            byte_ptr <= 1'b0;
        end else if (!access) begin
            byte_ptr <= 1'b0;
        end else begin
            byte_ptr <= !byte_ptr;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // The start flag is staged on the MSB byte and used only on commit
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_conversion_bit <= 1'b0;
            ctl_msb_seen         <= 1'b0;
        end else if (wr_ctl && !byte_ptr) begin
            start_conversion_bit <= bus_req.data[sab_pkg::START_BIT_POS];
            ctl_msb_seen         <= 1'b1;
        end else begin
            // Start bit self-clears on the next clock, whether a commit launched it or not
            start_conversion_bit <= 1'b0;
            ctl_msb_seen         <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            channel <= sab_pkg::CHANNEL_RESET;
        end else if (commit) begin
            channel <= bus_req.data[3:0];
        end
    end

    // Per-bit view of the channel address
    for (genvar i = 0; i < 4; i++) begin : g_chan
        assign channel_address_bits[i] = channel[i];
    end

    // ****************************************
    // Status flag
    // ****************************************
    // A new result in the same clock as a clearing write wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status <= 1'b0;
        end else if (done) begin
            status <= 1'b1;
        end else if (commit) begin
            status <= 1'b0;
        end
    end

    // ****************************************
    // Read words
    // ****************************************
    assign results_word = {status, 7'h00, result_bits};
    assign discrete_input_word = {
        4'h0,
        channel_address_bits[3], channel_address_bits[2],
        channel_address_bits[1], channel_address_bits[0],
        2'h0, discrete_pin_bits
    };

    always_comb begin
        if (bus_req.register_select_line) begin
            rd_byte = word_byte(discrete_input_word, byte_ptr);
        end else begin
            rd_byte = word_byte(results_word, byte_ptr);
        end
    end

    // Read data is registered, so the driver never glitches mid-clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else if (access && bus_req.rd_wr) begin
            data_out <= rd_byte;
            data_oe  <= 1'b1;
        end else begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end
    end

    // ****************************************
    // Converter
    // ****************************************
    sab_sar u_sar (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .start      (start),
        .comp_above (comp_above),
        .state      (state),
        .trial      (trial),
        .result     (result_bits),
        .done       (done)
    );

    // Analog-side outputs are registered copies so they never glitch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mux_select <= sab_pkg::CHANNEL_RESET;
        end else begin
            mux_select <= channel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dac_level <= 8'h00;
        end else begin
            dac_level <= trial;
        end
    end

    // Phase flags lag the sequencer by one clock, like the other outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acquiring  <= 1'b0;
            converting <= 1'b0;
        end else begin
            acquiring  <= state == sab_pkg::SAB_ACQ;
            converting <= state == sab_pkg::SAB_CONV;
        end
    end

    // ****************************************
    // Check helpers
    // ****************************************
    // Busy clocks since the last start, counted on the pins' phase flags; the
    // clock after a start is skipped because the flags still show the old phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_q     <= 1'b0;
            busy_clocks <= 9'h000;
        end else begin
            start_q <= start;
            if (start || start_q) begin
                busy_clocks <= 9'h000;
            end else if (acquiring || converting) begin
                busy_clocks <= busy_clocks + 9'h001;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    bus_ignored_a: assert property (
        bus_req.cs_n |=> !data_oe && data_out == 8'h00)
        else $error("bus answered while deselected");
    read_answer_a: assert property (
        (access && bus_req.rd_wr) |=> data_oe)
        else $error("read not answered");
    msb_first_a: assert property (
        (access && !byte_ptr) |=> byte_ptr)
        else $error("byte pointer did not move to LSB");
    ptr_return_a: assert property (
        bus_req.cs_n |=> !byte_ptr)
        else $error("byte pointer not back at MSB");
    disc_lsb_a: assert property (
        (access && bus_req.rd_wr && bus_req.register_select_line && byte_ptr)
        |=> data_out == {2'h0, $past(discrete_pin_bits)})
        else $error("discrete pins misreported");
    disc_msb_a: assert property (
        (access && bus_req.rd_wr && bus_req.register_select_line && !byte_ptr)
        |=> data_out == {4'h0, $past(channel)})
        else $error("channel address misreported");
    status_set_a: assert property (
        done |=> status)
        else $error("status not set on new result");
    status_hold_a: assert property (
        (status && !commit) |=> status)
        else $error("status cleared without full write");
    chan_latch_a: assert property (
        commit |=> channel == $past(bus_req.data[3:0]) ##1 mux_select == channel)
        else $error("channel address not latched");

    // Decode and byte order
    write_silent_a: assert property (
        (access && !bus_req.rd_wr) |=> !data_oe)
        else $error("bus driven during a write");
    noop_write_a: assert property (
        (access && !bus_req.rd_wr && !bus_req.register_select_line) |=> !ctl_msb_seen)
        else $error("no-op write staged a control byte");
    oe_cause_a: assert property (
        data_oe |-> $past(access && bus_req.rd_wr))
        else $error("bus driven without a read");
    lsb_second_a: assert property (
        (access && byte_ptr) |=> !byte_ptr)
        else $error("byte pointer did not return to MSB");
    commit_pair_a: assert property (
        commit |-> $past(wr_ctl && !byte_ptr))
        else $error("control taken without its MSB byte");
    start_staged_a: assert property (
        start |-> $past(wr_ctl && !byte_ptr && bus_req.data[sab_pkg::START_BIT_POS]))
        else $error("start without a staged start bit");
    results_msb_a: assert property (
        (access && bus_req.rd_wr && !bus_req.register_select_line && !byte_ptr)
        |=> data_out == {$past(status), 7'h00})
        else $error("status byte misreported");
    results_lsb_a: assert property (
        (access && bus_req.rd_wr && !bus_req.register_select_line && byte_ptr && status)
        |=> data_out == $past(result_bits))
        else $error("result byte misreported");

    // Status and channel register
    status_clear_a: assert property (
        (commit && !done) |=> !status)
        else $error("full control write did not clear status");
    chan_hold_a: assert property (
        !commit |=> channel == $past(channel))
        else $error("channel changed without a full write");

    // Converter phases as seen on the pins
    launch_acq_a: assert property (
        start |=> state == sab_pkg::SAB_ACQ ##1 acquiring)
        else $error("start did not begin acquisition");
    acq_dac_zero_a: assert property (
        acquiring |-> dac_level == 8'h00)
        else $error("trial level shown during acquisition");
    dac_posted_a: assert property (
        $rose(converting) |-> dac_level == sab_pkg::TRIAL_FIRST)
        else $error("first trial level is not the MSB");
    one_phase_a: assert property (
        !(acquiring && converting))
        else $error("acquisition and comparison overlap");
    conv_busy_a: assert property (
        ($fell(converting) && !acquiring) |-> busy_clocks == 9'(sab_pkg::CONV_CLOCKS))
        else $error("conversion not 256 clocks at the pins");

endmodule

`default_nettype wire

/* tb/sab_comparator_model.sv */
// Purpose: Behavioural comparator and ladder standing at the converter's analog side
// Assumes: The analog input is given as an 8-bit code, ladder tap equals dac_level
// Notes:   Ideal and instant; the design holds dac_level for a whole bit period
`default_nettype none

module sab_comparator_model (
    // Analog input and ladder tap
    input  wire logic [7:0] input_level,
    input  wire logic [7:0] dac_level,
    // Decision
    output logic            comp_above
);
    timeunit 1ns;
    timeprecision 1ps;

    // At or above the tap keeps the trial bit, so a code input converts exactly
    assign comp_above = (input_level >= dac_level);
endmodule

`default_nettype wire

/* tb/sar_adc_bus_sequencer_test.sv */
// Purpose: Self-checking bench for the converter bus sequencer
// Assumes: Bench drives the processor bus just after rising edges
// Notes:   Read bytes are sampled at the falling edge where they stand settled
`default_nettype none

module sar_adc_bus_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk;
    logic               rst;
    sab_pkg::sab_req_t  bus_req;
    logic [7:0]         data_out;
    logic               data_oe;
    logic               comp_above;
    logic [5:0]         discrete_pin_bits;
    logic [3:0]         mux_select;
    logic [7:0]         dac_level;
    logic               acquiring;
    logic               converting;
    logic [7:0]         input_level;
    logic [7:0]         msb;
    logic [7:0]         lsb;
    int                 n_mismatch;
    int                 n_checks;
    localparam logic [3:0] CHANS [4]  = '{4'h3, 4'h5, 4'hA, 4'hF};
    localparam logic [7:0] LEVELS [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};

    sab_top i_dut (
        .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .data_out(data_out),
        .data_oe(data_oe), .comp_above(comp_above), .discrete_pin_bits(discrete_pin_bits),
        .mux_select(mux_select), .dac_level(dac_level), .acquiring(acquiring),
        .converting(converting)
    );

    sab_comparator_model i_comp (
        .input_level(input_level), .dac_level(dac_level), .comp_above(comp_above)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ****************************************
    // Comparison and bus tasks
    // ****************************************
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one idle select clock behind
    task automatic write_word(input logic rs, input logic [7:0] hi, input logic [7:0] lo);
        bus_req <= '{1'b0, 1'b0, rs, hi};
        @(posedge ref_clk);
        bus_req.data <= lo;
        @(posedge ref_clk);
        bus_req.cs_n <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic read_word(input logic rs, input int nbytes,
                             output logic [7:0] hi, output logic [7:0] lo);
        lo = 8'h00;
        bus_req <= '{1'b0, 1'b1, rs, 8'h00};
        @(posedge ref_clk);
        if (nbytes == 1) bus_req.cs_n <= 1'b1;
        @(negedge ref_clk);
        hi = data_out;
        check8({7'h00, data_oe}, 8'h01);
        if (nbytes == 2) begin
            @(posedge ref_clk);
            bus_req.cs_n <= 1'b1;
            @(negedge ref_clk);
            lo = data_out;
            check8({7'h00, data_oe}, 8'h01);
        end
        // Two idle clocks so the byte pointer is back on the high byte
        @(posedge ref_clk);
        @(posedge ref_clk);
    endtask

    task automatic run_conversion(input logic [3:0] ch, input logic [7:0] level);
        int n_acq;
        int n_conv;
        n_acq = 0;
        n_conv = 0;
        input_level <= level;
        write_word(1'b1, 8'h01, {4'h0, ch});
        // Fixed span: the whole conversion is 256 clocks plus output latency
        repeat (300) begin
            @(negedge ref_clk);
            if (acquiring === 1'b1) n_acq++;
            if (converting === 1'b1) n_conv++;
        end
        check_count(n_acq, sab_pkg::ACQ_CLOCKS);
        check_count(n_conv, sab_pkg::CONV_CLOCKS - sab_pkg::ACQ_CLOCKS);
        check8({4'h0, mux_select}, {4'h0, ch});
        @(posedge ref_clk);
        read_word(1'b0, 2, msb, lsb);
        check8(msb, 8'h80);
        check8(lsb, level);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        bus_req = '{1'b1, 1'b0, 1'b0, 8'h00};
        discrete_pin_bits = 6'h2A;
        input_level = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check8({data_oe, acquiring, converting, 1'b0, mux_select}, 8'h00);
        check8(dac_level, 8'h00);
        @(posedge ref_clk);
        read_word(1'b0, 2, msb, lsb);
        check8(msb, 8'h00);
        $display("test reset done");

        // Deselected read and no-op write must leave everything quiet
        bus_req <= '{1'b1, 1'b1, 1'b1, 8'h00};
        @(posedge ref_clk);
        @(negedge ref_clk);
        check8({7'h00, data_oe}, 8'h00);
        @(posedge ref_clk);
        write_word(1'b0, 8'h01, 8'h05);
        @(negedge ref_clk);
        check8({2'h0, acquiring, converting, mux_select}, 8'h00);
        @(posedge ref_clk);
        read_word(1'b1, 2, msb, lsb);
        check8(msb, 8'h00);
        check8(lsb, 8'h2A);
        $display("test decode done");

        // Single byte, then a whole word must again start on the high byte
        discrete_pin_bits <= 6'h15;
        read_word(1'b1, 1, msb, lsb);
        check8(msb, 8'h00);
        read_word(1'b1, 2, msb, lsb);
        check8(msb, 8'h00);
        check8(lsb, 8'h15);
        $display("test byte pointer done");

        for (int i = 0; i < 4; i++) begin
            run_conversion(CHANS[i], LEVELS[i]);
            read_word(1'b1, 2, msb, lsb);
            check8(msb, {4'h0, CHANS[i]});
        end
        read_word(1'b0, 1, msb, lsb);
        check8(msb, 8'h80);
        $display("test conversions done");

        // Channel-only write clears status; old result survives a new run
        write_word(1'b1, 8'h00, 8'h02);
        read_word(1'b0, 2, msb, lsb);
        check8(msb, 8'h00);
        check8(lsb, LEVELS[3]);
        input_level <= 8'h11;
        write_word(1'b1, 8'h01, 8'h04);
        // Far into the comparisons, so the restart below is a real abort
        repeat (100) @(posedge ref_clk);
        read_word(1'b0, 2, msb, lsb);
        check8(msb, 8'h00);
        check8(lsb, LEVELS[3]);
        $display("test result hold done");

        // A new start aborts the running conversion and acquires afresh
        run_conversion(4'h4, 8'h3C);
        // A lone MSB control byte is not a full write: no start, status kept
        bus_req <= '{1'b0, 1'b0, 1'b1, 8'h01};
        @(posedge ref_clk);
        bus_req.cs_n <= 1'b1;
        @(posedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
        check8({6'h00, acquiring, converting}, 8'h00);
        @(posedge ref_clk);
        read_word(1'b0, 1, msb, lsb);
        check8(msb, 8'h80);
        $display("test abort done");

        // Reset clears status and channel; the data register keeps its result
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        read_word(1'b0, 2, msb, lsb);
        check8(msb, 8'h00);
        check8(lsb, 8'h3C);
        read_word(1'b1, 2, msb, lsb);
        check8(msb, 8'h00);
        $display("test reset hold done");
        complete_run();
    end

    // Tests need about 1,700 clocks; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        $display("watchdog expired at %0t", $time);
        complete_run();
    end
endmodule

`default_nettype wire
